/* File: shared/eisa_pkg.sv */
// Contract
// - after reset and by default every extension feature is inactive.
// - extended instructions and indexed literal offset mode only while fuse is set.
// - when enabled decode eight added instructions plus indexed literal offset addressing.
// - pointer add is 1110 1000 ffkk kkkk, one cycle, pointer 0..2, no flags.
// - pointer add sums unsigned six-bit literal into the selected pointer.
// - pointer-2 add with return is 1110 1000 11kk kkkk, two cycles, no flags.
// - pointer subtract is 1110 1001 ffkk kkkk, one cycle, no flags.
// - pointer-2 subtract with return is 1110 1001 11kk kkkk, two cycles, no flags.
// - register-target call is 0x0014, target from working register, two cycles, no flags.
// - indexed moves are 1110 1011, bit 7 picks kind, second word 1111, two cycles.
// - push literal stores literal at frame pointer then decrements it, one cycle.
// - access bit clear and address at most 95 selects indexed literal offset addressing.
// - return variants update pointer and load pc from stack top, then no-operation.
// - return variants are pointer add or subtract with select 11, frame pointer only.
package eisa_pkg;
    localparam int PTR_W = 12;
    localparam int PC_W  = 21;
    localparam logic [3:0] OP_HI_EXT   = 4'he;
    localparam logic [3:0] OP_ADD      = 4'h8;
    localparam logic [3:0] OP_SUB      = 4'h9;
    localparam logic [3:0] OP_PUSH     = 4'ha;
    localparam logic [3:0] OP_MOVE     = 4'hb;
    localparam logic [3:0] OP_SECOND   = 4'hf;
    localparam logic [15:0] OP_CALL_VIA_WORKING_REG   = 16'h0014;
    localparam logic [1:0] SEL_FRAME   = 2'h3;
    localparam logic [1:0] FRAME_IDX   = 2'h2;
    localparam logic [7:0] ILO_LIMIT   = 8'h5f;
    localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
    localparam int K6_LSB = 0;
    localparam int K6_W   = 6;
    localparam int SEL_LSB = 6;
    localparam int MOVE_KIND_BIT = 7;

    typedef enum logic [3:0] {
        EISA_NONE, EISA_ADD, EISA_SUB, EISA_ADDRET, EISA_SUBRET,
        EISA_CALL_VIA_WORKING_REG, EISA_MOVE_INDEXED_TO_FILE, EISA_MOVE_INDEXED_TO_INDEXED, EISA_PUSH
    } eisa_op_e;

    // memory write request toward the data bus
    typedef struct packed {
        logic             valid;
        logic [PTR_W-1:0] addr;
        logic [7:0]       data;
    } eisa_wr_s;

    // program flow request toward the pc logic
    typedef struct packed {
        logic            loadTos;
        logic            call_via_working_reg;
        logic [PC_W-1:0] retAddr;
    } eisa_flow_s;
endpackage : eisa_pkg

/* File: rtl/eisa_decode.sv */
`timescale 1ns/1ns
module eisa_decode
    import eisa_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             extFuse,
    input  wire logic             instrValid,
    input  wire logic [15:0]      instrWord,
    input  wire logic [PC_W-1:0]  pcPlus2,
    input  wire logic [7:0]       stdFileAddr,
    input  wire logic             stdAccessBit,
    input  wire logic             stdByteOp,
    input  wire logic [PTR_W-1:0] ptrLoad,
    input  wire logic [1:0]       ptrLoadSel,
    input  wire logic             ptrLoadEn,
    output logic [PTR_W-1:0]      ptr [3],
    output eisa_op_e              curOp,
    output logic                  busy,
    output eisa_wr_s              memWr,
    output eisa_flow_s            flow,
    output logic [PTR_W-1:0]      srcAddr,
    output logic [PTR_W-1:0]      dstAddr,
    output logic                  dstIndexed,
    output logic                  indexedMode,
    output logic [PTR_W-1:0]      indexedAddr,
    output logic                  illegal
);
    typedef enum logic [1:0] {IDLE, SECOND, NOPCYC} eisa_state_e;

    eisa_state_e      state, next_state;
    eisa_op_e         next_curOp, dec;
    logic [PTR_W-1:0] next_ptr [3];
    eisa_wr_s         next_memWr;
    eisa_flow_s       next_flow;
    logic [PTR_W-1:0] next_srcAddr, next_dstAddr;
    logic             next_dstIndexed, next_illegal;
    logic [1:0]       sel;
    logic [PTR_W-1:0] k6;

    assign sel = instrWord[SEL_LSB +: 2];
    assign k6  = PTR_W'(instrWord[K6_LSB +: K6_W]);

    always_comb begin
        dec = EISA_NONE;
        if (extFuse) begin
            if (instrWord == OP_CALL_VIA_WORKING_REG)
                dec = EISA_CALL_VIA_WORKING_REG;
            else if (instrWord[15:12] == OP_HI_EXT) begin
                case (instrWord[11:8])
                    OP_ADD:  dec = (sel == SEL_FRAME) ? EISA_ADDRET : EISA_ADD;
                    OP_SUB:  dec = (sel == SEL_FRAME) ? EISA_SUBRET : EISA_SUB;
                    OP_PUSH: dec = EISA_PUSH;
                    OP_MOVE: dec = instrWord[MOVE_KIND_BIT] ? EISA_MOVE_INDEXED_TO_INDEXED : EISA_MOVE_INDEXED_TO_FILE;
                    default: dec = EISA_NONE;
                endcase
            end
        end
    end

    // indexed literal offset addressing for standard byte instructions
    always_comb begin
        indexedMode = extFuse && stdByteOp && !stdAccessBit
                      && (stdFileAddr <= ILO_LIMIT);
        indexedAddr = ptr[FRAME_IDX] + PTR_W'(stdFileAddr);
    end

    always_comb begin
        next_state      = state;
        next_curOp      = EISA_NONE;
        next_ptr        = ptr;
        next_memWr      = '0;
        next_flow       = '0;
        next_srcAddr    = srcAddr;
        next_dstAddr    = dstAddr;
        next_dstIndexed = dstIndexed;
        next_illegal    = 1'b0;
        if (ptrLoadEn && ptrLoadSel != SEL_FRAME)
            next_ptr[ptrLoadSel] = ptrLoad;
        case (state)
            IDLE: begin
                if (instrValid) begin
                    next_curOp = dec;
                    case (dec)
                        EISA_ADD: next_ptr[sel] = ptr[sel] + k6;
                        EISA_SUB: next_ptr[sel] = ptr[sel] - k6;
                        EISA_ADDRET, EISA_SUBRET: begin
                            next_ptr[FRAME_IDX] = (dec == EISA_ADDRET)
                                ? ptr[FRAME_IDX] + k6
                                : ptr[FRAME_IDX] - k6;
                            next_flow.loadTos = 1'b1;
                            next_state = NOPCYC;
                        end
                        EISA_CALL_VIA_WORKING_REG: begin
                            next_flow.call_via_working_reg   = 1'b1;
                            next_flow.retAddr = pcPlus2;
                            next_state = NOPCYC;
                        end
                        EISA_PUSH: begin
                            next_memWr.valid = 1'b1;
                            next_memWr.addr  = ptr[FRAME_IDX];
                            next_memWr.data  = instrWord[7:0];
                            next_ptr[FRAME_IDX] = ptr[FRAME_IDX] - PTR_W'(1);
                        end
                        EISA_MOVE_INDEXED_TO_FILE, EISA_MOVE_INDEXED_TO_INDEXED: begin
                            next_srcAddr = ptr[FRAME_IDX]
                                + PTR_W'(instrWord[6:0]);
                            next_dstIndexed = (dec == EISA_MOVE_INDEXED_TO_INDEXED);
                            next_state = SECOND;
                        end
                        default: ;
                    endcase
                end
            end
            SECOND: begin
                next_curOp = curOp;
                if (instrValid) begin
                    next_illegal = (instrWord[15:12] != OP_SECOND);
                    next_dstAddr = dstIndexed
                        ? ptr[FRAME_IDX] + PTR_W'(instrWord[6:0])
                        : instrWord[PTR_W-1:0];
                    next_state = IDLE;
                end
            end
            NOPCYC: next_state = IDLE;
            default: next_state = IDLE;
        endcase
        if (ptrLoadEn && ptrLoadSel == FRAME_IDX && state != IDLE)
            next_ptr[FRAME_IDX] = ptrLoad;
    end

    assign busy = (state != IDLE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state      <= IDLE;
            curOp      <= EISA_NONE;
            memWr      <= '0;
            flow       <= '0;
            srcAddr    <= PTR_RESET;
            dstAddr    <= PTR_RESET;
            dstIndexed <= 1'b0;
            illegal    <= 1'b0;
        end else begin
            state      <= next_state;
            curOp      <= next_curOp;
            memWr      <= next_memWr;
            flow       <= next_flow;
            srcAddr    <= next_srcAddr;
            dstAddr    <= next_dstAddr;
            dstIndexed <= next_dstIndexed;
            illegal    <= next_illegal;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ptr
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    ptr[gi] <= PTR_RESET;
                else
                    ptr[gi] <= next_ptr[gi];
            end
        end
    endgenerate

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    fuse_gate_a: assert property (!extFuse && instrValid && !busy |=> curOp == EISA_NONE)
        else $error("extension decoded with fuse clear");
    ilo_gate_a: assert property (indexedMode |-> extFuse && stdFileAddr <= 8'h5f)
        else $error("indexed mode outside its window");
    add_ptr_a: assert property (!busy && instrValid && dec == EISA_ADD && !ptrLoadEn
        |=> ptr[$past(sel)] == $past(ptr[sel]) + $past(k6))
        else $error("pointer add wrong sum");
    sub_ptr_a: assert property (!busy && instrValid && dec == EISA_SUB && !ptrLoadEn
        |=> ptr[$past(sel)] == $past(ptr[sel]) - $past(k6))
        else $error("pointer subtract wrong");
    ret_two_a: assert property (!busy && instrValid && (dec == EISA_ADDRET || dec == EISA_SUBRET)
        |=> flow.loadTos && busy ##1 !busy && !flow.loadTos)
        else $error("return variant timing wrong");
    call_via_working_reg_two_a: assert property (!busy && instrValid && dec == EISA_CALL_VIA_WORKING_REG
        |=> flow.call_via_working_reg && flow.retAddr == $past(pcPlus2) ##1 !busy)
        else $error("register call wrong");
    push_dec_a: assert property (!busy && instrValid && dec == EISA_PUSH && !ptrLoadEn
        |=> memWr.valid && memWr.addr == $past(ptr[2])
            && ptr[2] == $past(ptr[2]) - 12'h001)
        else $error("push literal wrong");
    move_two_a: assert property (!busy && instrValid && (dec == EISA_MOVE_INDEXED_TO_FILE || dec == EISA_MOVE_INDEXED_TO_INDEXED)
        |=> busy && srcAddr == $past(ptr[2]) + {5'h00, $past(instrWord[6:0])})
        else $error("indexed move wrong");
    // return variants touch only the frame pointer
    ret_frame_a: assert property (!busy && instrValid && !ptrLoadEn
        && (dec == EISA_ADDRET || dec == EISA_SUBRET)
        |=> ptr[0] == $past(ptr[0]) && ptr[1] == $past(ptr[1]))
        else $error("return variant touched another pointer");
    addret_sum_a: assert property (!busy && instrValid && dec == EISA_ADDRET
        |=> ptr[2] == $past(ptr[2]) + $past(k6))
        else $error("return add wrong sum");
    subret_sum_a: assert property (!busy && instrValid && dec == EISA_SUBRET
        |=> ptr[2] == $past(ptr[2]) - $past(k6))
        else $error("return subtract wrong");
    add_one_a: assert property (!busy && instrValid && (dec == EISA_ADD || dec == EISA_SUB)
        |=> !busy)
        else $error("pointer add took extra cycle");
    push_one_a: assert property (!busy && instrValid && dec == EISA_PUSH
        |=> !busy)
        else $error("push took extra cycle");
    move_end_a: assert property (state == SECOND && instrValid
        |=> !busy)
        else $error("move not done after second word");
    move_bad_a: assert property (state == SECOND && instrValid && instrWord[15:12] != 4'hf
        |=> illegal)
        else $error("bad second move word not flagged");
    move_indexed_to_indexed_dst_a: assert property (state == SECOND && instrValid && dstIndexed
        |=> dstAddr == $past(ptr[2]) + {5'h00, $past(instrWord[6:0])})
        else $error("indexed destination wrong");
    // second cycle of a return or call does nothing
    nop_idle_a: assert property (state == NOPCYC
        |=> !memWr.valid && curOp == EISA_NONE && !flow.loadTos)
        else $error("no-operation cycle had effect");

    cov_addret_c: cover property (curOp == EISA_ADDRET ##1 !busy);
    cov_call_via_working_reg_c: cover property (flow.call_via_working_reg ##1 !busy);
    cov_move_indexed_to_indexed_c: cover property (curOp == EISA_MOVE_INDEXED_TO_INDEXED ##1 !busy);
    cov_push_c: cover property (memWr.valid);
    cov_ilo_c: cover property (indexedMode);
endmodule : eisa_decode

/* File: tb/test_extended_isa_decode.sv */
`timescale 1ns/1ns
module test_extended_isa_decode import eisa_pkg::*;;
    logic             clk, nrst, extFuse, instrValid, stdAccessBit, stdByteOp, ptrLoadEn;
    logic [15:0]      instrWord;
    logic [PC_W-1:0]  pcPlus2;
    logic [7:0]       stdFileAddr;
    logic [PTR_W-1:0] ptrLoad, srcAddr, dstAddr, indexedAddr;
    logic [1:0]       ptrLoadSel;
    logic [PTR_W-1:0] ptr [3];
    eisa_op_e         curOp;
    eisa_wr_s         memWr;
    eisa_flow_s       flow;
    logic             busy, dstIndexed, indexedMode, illegal;
    int               n_fail = 0;
    int               cmp_count = 0;

    eisa_decode dut (.clk(clk), .nrst(nrst), .extFuse(extFuse), .instrValid(instrValid),
        .instrWord(instrWord), .pcPlus2(pcPlus2), .stdFileAddr(stdFileAddr),
        .stdAccessBit(stdAccessBit), .stdByteOp(stdByteOp), .ptrLoad(ptrLoad),
        .ptrLoadSel(ptrLoadSel), .ptrLoadEn(ptrLoadEn), .ptr(ptr), .curOp(curOp),
        .busy(busy), .memWr(memWr), .flow(flow), .srcAddr(srcAddr), .dstAddr(dstAddr),
        .dstIndexed(dstIndexed), .indexedMode(indexedMode), .indexedAddr(indexedAddr),
        .illegal(illegal));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // one word presented for one edge, outputs looked at after the taking edge
    task automatic issue(input logic [15:0] w);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord  <= w;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask : issue

    task automatic move(input logic [15:0] w1, input logic [15:0] w2);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord  <= w1;
        @(posedge clk);
        instrWord  <= w2;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask : move

    task automatic loadp(input logic [1:0] s, input logic [PTR_W-1:0] v);
        @(posedge clk);
        ptrLoadEn  <= 1'b1;
        ptrLoadSel <= s;
        ptrLoad    <= v;
        @(posedge clk);
        ptrLoadEn  <= 1'b0;
        #1;
    endtask : loadp

    task automatic ilo(input logic a, input logic [7:0] f, input logic m,
                       input logic [PTR_W-1:0] ea);
        @(posedge clk);
        stdAccessBit <= a;
        stdByteOp    <= 1'b1;
        stdFileAddr  <= f;
        #1;
        check("indexedMode", m, indexedMode);
        if (m) check("indexedAddr", ea, indexedAddr);
    endtask : ilo

    task automatic t_reset;
        #1;
        for (int i = 0; i < 3; i++) check("ptr", PTR_RESET, ptr[i]);
        check("curOp", EISA_NONE, curOp);
        check("busy", 1'b0, busy);
        check("memWr.valid", 1'b0, memWr.valid);
    endtask : t_reset

    task automatic t_fuse_off;
        issue(16'he805);
        check("ptr0", 12'h000, ptr[0]);
        check("curOp", EISA_NONE, curOp);
        issue(16'h0014);
        check("flow.call_via_working_reg", 1'b0, flow.call_via_working_reg);
        ilo(1'b0, 8'h10, 1'b0, 12'h000);
    endtask : t_fuse_off

    task automatic t_ptr_math;
        @(posedge clk) extFuse <= 1'b1;
        loadp(2'h2, 12'h3ff);
        issue(16'he8a3);
        check("ptr2", 12'h422, ptr[2]);
        check("curOp", EISA_ADD, curOp);
        loadp(2'h0, 12'h010);
        issue(16'he93f);
        check("ptr0", 12'hfd1, ptr[0]);
        check("ptr2", 12'h422, ptr[2]);
        check("curOp", EISA_SUB, curOp);
    endtask : t_ptr_math

    task automatic t_return;
        issue(16'he8c5);
        check("ptr2", 12'h427, ptr[2]);
        check("flow.loadTos", 1'b1, flow.loadTos);
        check("busy", 1'b1, busy);
        check("curOp", EISA_ADDRET, curOp);
        @(posedge clk);
        #1;
        check("busy", 1'b0, busy);
        check("flow.loadTos", 1'b0, flow.loadTos);
        issue(16'he9c7);
        check("ptr2", 12'h420, ptr[2]);
        check("flow.loadTos", 1'b1, flow.loadTos);
        check("curOp", EISA_SUBRET, curOp);
    endtask : t_return

    task automatic t_call_via_working_reg;
        @(posedge clk) pcPlus2 <= 21'h01234;
        issue(16'h0014);
        check("flow.call_via_working_reg", 1'b1, flow.call_via_working_reg);
        check("flow.retAddr", 21'h01234, flow.retAddr);
        check("busy", 1'b1, busy);
    endtask : t_call_via_working_reg

    task automatic t_push;
        issue(16'hea5a);
        check("memWr.valid", 1'b1, memWr.valid);
        check("memWr.addr", 12'h420, memWr.addr);
        check("memWr.data", 8'h5a, memWr.data);
        check("ptr2", 12'h41f, ptr[2]);
        check("curOp", EISA_PUSH, curOp);
    endtask : t_push

    task automatic t_moves;
        move(16'heb05, 16'hf123);
        check("srcAddr", 12'h424, srcAddr);
        check("dstAddr", 12'h123, dstAddr);
        check("dstIndexed", 1'b0, dstIndexed);
        check("curOp", EISA_MOVE_INDEXED_TO_FILE, curOp);
        move(16'heb85, 16'hf00a);
        check("srcAddr", 12'h424, srcAddr);
        check("dstAddr", 12'h429, dstAddr);
        check("dstIndexed", 1'b1, dstIndexed);
        check("curOp", EISA_MOVE_INDEXED_TO_INDEXED, curOp);
        move(16'heb05, 16'h0123);
        check("illegal", 1'b1, illegal);
    endtask : t_moves

    task automatic t_reset_mid;
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        for (int i = 0; i < 3; i++) check("ptr", PTR_RESET, ptr[i]);
        check("busy", 1'b0, busy);
        @(posedge clk);
        nrst <= 1'b1;
        issue(16'he801);
        check("ptr0", 12'h001, ptr[0]);
    endtask : t_reset_mid

    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end

    initial begin
        nrst = 1'b0;
        extFuse = 1'b0;
        instrValid = 1'b0;
        instrWord = 16'h0000;
        pcPlus2 = '0;
        stdFileAddr = 8'h00;
        stdAccessBit = 1'b1;
        stdByteOp = 1'b0;
        ptrLoad = '0;
        ptrLoadSel = 2'h0;
        ptrLoadEn = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_fuse_off;
        t_ptr_math;
        t_return;
        t_call_via_working_reg;
        t_push;
        t_moves;
        ilo(1'b0, 8'h5f, 1'b1, 12'h47e);
        ilo(1'b0, 8'h60, 1'b0, 12'h000);
        ilo(1'b1, 8'h05, 1'b0, 12'h000);
        t_reset_mid;
        tally_and_finish;
    end
endmodule : test_extended_isa_decode
